// ### include/pcdcs_params.svh
// Purpose: Constants for the device control and status register bank
// Assumes: APB with 32-bit data, 12-bit byte address
// Notes:   Printed offsets are word indices; byte address is four times index
`ifndef PCDCS_PARAMS_SVH
`define PCDCS_PARAMS_SVH

// ----------------------------------------------------------------------
// Bus geometry
// ----------------------------------------------------------------------
`define PCDCS_ADDR_W          12
`define PCDCS_DATA_W          32

// ----------------------------------------------------------------------
// Register indices and byte addresses
// ----------------------------------------------------------------------
`define PCDCS_CTRL_IDX        12'h048
`define PCDCS_STAT_IDX        12'h04a
`define PCDCS_CTRL_ADDR       12'h120
`define PCDCS_STAT_ADDR       12'h128
`define PCDCS_MASK_ADDR       12'h200
`define PCDCS_TLC_ADDR        12'h204

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define PCDCS_CORR_BIT        0
`define PCDCS_NFAT_BIT        1
`define PCDCS_FAT_BIT         2
`define PCDCS_UNSUP_BIT       3
`define PCDCS_RO_BIT          4
`define PCDCS_MPS_LSB         5
`define PCDCS_MPS_MSB         7
`define PCDCS_WTAG_BIT        8
`define PCDCS_SEQUENTIAL_TAG_DEBUG_BIT      0
`define PCDCS_ERR_MSB         3

// ----------------------------------------------------------------------
// Reset values and codes
// ----------------------------------------------------------------------
`define PCDCS_ERR_RST         4'h0
`define PCDCS_MPS_RST         3'h0
`define PCDCS_TAG_RST         8'h00
`define PCDCS_MPS_128         3'h0
`define PCDCS_MPS_256         3'h1
`define PCDCS_MPS_512         3'h2
`define PCDCS_MPS_1024        3'h3
`define PCDCS_MPS_2048        3'h4
`define PCDCS_BYTES_128       12'h080
`define PCDCS_BYTES_256       12'h100
`define PCDCS_BYTES_512       12'h200
`define PCDCS_BYTES_1024      12'h400
`define PCDCS_BYTES_2048      12'h800
`define PCDCS_NARROW_TAG_MAX  8'h1f
`define PCDCS_WIDE_TAG_MAX    8'hff

`endif

// ### include/pcdcs_pkg.sv
// Purpose: Types for the device control and status register bank
// Assumes: Constants come from pcdcs_params.svh
// Notes:   One-hot state codes written out
package pcdcs_pkg;

    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        PCDCS_ST_IDLE = 2'b01,
        PCDCS_ST_RESP = 2'b10
    } pcdcs_apb_e;

    typedef logic [3:0] pcdcs_err_t;
    typedef logic [3:0] pcdcs_sel_t;

endpackage : pcdcs_pkg

// ### src/pcdcs_tag_gen.sv
// Purpose: Debug sequential tag generator
// Assumes: tag_req is a one-cycle pulse per new tag
// Notes:   Tag holds zero while the debug option is off
`timescale 1ns/1ps
`include "pcdcs_params.svh"

module pcdcs_tag_gen (
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic       seq_debug,
    input  wire logic       wide_tag_en,
    input  wire logic       tag_req,
    output logic [7:0]      tag
);

    logic [7:0] tag_reg;
    logic [7:0] tag_next;

    // ------------------------------------------------------------------
    // Tag sequence
    // ------------------------------------------------------------------
    always_comb begin
        tag_next = tag_reg;
        if (!seq_debug) begin
            tag_next = `PCDCS_TAG_RST;
        end else if (tag_req) begin
            // Narrow range wraps by masking, so a stale wide tag folds back
            if (wide_tag_en) begin
                tag_next = (tag_reg == `PCDCS_WIDE_TAG_MAX) ? `PCDCS_TAG_RST
                                                            : tag_reg + 8'h01; // R8
            end else begin
                tag_next = (tag_reg + 8'h01) & `PCDCS_NARROW_TAG_MAX; // R8
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tag_reg <= `PCDCS_TAG_RST;
        end else begin
            tag_reg <= tag_next;
        end
    end

    assign tag = tag_reg;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    a_tag_narrow: assert property ( // R8
        @(posedge pclk) disable iff (!presetn)
        (tag_req && seq_debug && !wide_tag_en) |=> (tag <= `PCDCS_NARROW_TAG_MAX))
        else $error("narrow tag out of range");

    a_tag_idle: assert property ( // R8
        @(posedge pclk) disable iff (!presetn)
        !seq_debug |=> (tag == `PCDCS_TAG_RST))
        else $error("tag moved without debug option");

    c_tag_wide_wrap: cover property (
        @(posedge pclk) disable iff (!presetn)
        (tag == `PCDCS_WIDE_TAG_MAX) && tag_req && seq_debug && wide_tag_en ##1
        (tag == `PCDCS_TAG_RST));

endmodule : pcdcs_tag_gen

// ### src/pcdcs_regs.sv
// Purpose: Device control and device status registers of one switch port
// Assumes: Error detect inputs are one-cycle pulses, one per event
// Notes:   APB slave with one wait state; unmapped addresses answer pslverr
//
// Register access over APB was decided locally.
`timescale 1ns/1ps
`include "pcdcs_params.svh"

// Contract
// R1 - Control bit 0, reset zero, gates sending correctable error reports
// R2 - Control bit 1, reset zero, gates sending non-fatal error reports
// R3 - Control bit 2, reset zero, gates sending fatal error reports
// R4 - Control bit 3, reset zero, gates sending unsupported request reports
// R5 - Relaxed ordering bit 4 reads zero; originated requests never set it
// R6 - Payload field 7:5 read-write; codes 0 to 4 select 128 to 2048 bytes
// R7 - Payload codes 5 to 7 apply a 128 byte maximum
// R8 - Bit 8 picks tag range 0-31 or 0-255 only under tag debug
// R9 - Phantom function bit 9 reads zero and ignores writes
// R10 - Aux power enable bit 10 reads zero and ignores writes
// R11 - No snoop bit 11 reads zero; never originated, forwarded unchanged
// R12 - Read request size reads zero; originated requests at most 128 bytes
// R13 - Status bits 0-3 set on detection regardless of enables; write one clears
// R14 - Status bit 2 sets on fatal error and holds until written one
// R15 - Status bit 3 sets on unsupported request and holds until cleared
// R16 - Aux power detected status bit 4 always reads zero
// R17 - Transactions pending status bit 5 always reads zero
// R18 - Enabled detection raises one report request pulse per event
module pcdcs_regs (
    input  wire logic                      pclk,
    input  wire logic                      presetn,
    input  wire logic                      psel,
    input  wire logic                      penable,
    input  wire logic                      pwrite,
    input  wire logic [`PCDCS_ADDR_W-1:0]  paddr,
    input  wire logic [`PCDCS_DATA_W-1:0]  pwdata,
    input  wire logic [3:0]                pstrb,
    output logic [`PCDCS_DATA_W-1:0]       prdata,
    output logic                           pready,
    output logic                           pslverr,
    input  wire logic                      corr_err_det,
    input  wire logic                      nonfatal_err_det,
    input  wire logic                      fatal_err_det,
    input  wire logic                      unsup_req_det,
    input  wire logic                      tag_req,
    input  wire logic                      fwd_no_snoop_in,
    input  wire logic [11:0]               fwd_len_in,
    output logic                           corr_err_report,
    output logic                           nonfatal_err_report,
    output logic                           fatal_err_report,
    output logic                           unsup_req_report,
    output logic [11:0]                    max_payload_bytes,
    output logic [11:0]                    req_max_read_bytes,
    output logic                           req_relaxed_order,
    output logic                           req_no_snoop,
    output logic                           fwd_no_snoop_out,
    output logic [11:0]                    fwd_len_out,
    output logic [7:0]                     req_tag,
    output logic                           irq
);

    // ------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------
    pcdcs_pkg::pcdcs_apb_e  apb_state_reg;
    pcdcs_pkg::pcdcs_err_t  err_en_reg;
    pcdcs_pkg::pcdcs_err_t  err_seen_reg;
    pcdcs_pkg::pcdcs_err_t  err_seen_next;
    pcdcs_pkg::pcdcs_err_t  err_mask_reg;
    pcdcs_pkg::pcdcs_err_t  err_det;
    pcdcs_pkg::pcdcs_err_t  err_report_reg;
    pcdcs_pkg::pcdcs_err_t  err_clr;
    pcdcs_pkg::pcdcs_sel_t  wr_sel;
    logic [2:0]             max_payload_sel_reg;
    logic                   wide_tag_en_reg;
    logic                   sequential_tag_debug_reg;
    logic [`PCDCS_DATA_W-1:0] prdata_reg;
    logic [`PCDCS_DATA_W-1:0] rd_word;
    logic                   pready_reg;
    logic                   pslverr_reg;
    logic                   irq_reg;
    logic [11:0]            max_payload_bytes_reg;
    logic                   fwd_no_snoop_reg;
    logic [11:0]            fwd_len_reg;
    logic                   wr_fire;
    logic                   rsp_ctrl_reg;
    logic                   rsp_stat_reg;

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    // One-hot: control, status, mask, transaction layer control
    function automatic pcdcs_pkg::pcdcs_sel_t addr_sel(input logic [`PCDCS_ADDR_W-1:0] a);
        addr_sel = 4'h0;
        if (a == `PCDCS_CTRL_ADDR) begin
            addr_sel = 4'h1;
        end else if (a == `PCDCS_STAT_ADDR) begin
            addr_sel = 4'h2;
        end else if (a == `PCDCS_MASK_ADDR) begin
            addr_sel = 4'h4;
        end else if (a == `PCDCS_TLC_ADDR) begin
            addr_sel = 4'h8;
        end
    endfunction : addr_sel

    function automatic logic [11:0] payload_bytes(input logic [2:0] code);
        unique case (code)
            `PCDCS_MPS_256:  payload_bytes = `PCDCS_BYTES_256;  // R6
            `PCDCS_MPS_512:  payload_bytes = `PCDCS_BYTES_512;  // R6
            `PCDCS_MPS_1024: payload_bytes = `PCDCS_BYTES_1024; // R6
            `PCDCS_MPS_2048: payload_bytes = `PCDCS_BYTES_2048; // R6
            default:         payload_bytes = `PCDCS_BYTES_128;  // R7
        endcase
    endfunction : payload_bytes

    assign err_det = {unsup_req_det, fatal_err_det, nonfatal_err_det, corr_err_det};

    // ------------------------------------------------------------------
    // APB handshake
    // ------------------------------------------------------------------
    // One wait state keeps read data registered without a deep mux path
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            apb_state_reg <= pcdcs_pkg::PCDCS_ST_IDLE;
            pready_reg    <= 1'b0;
        end else begin
            unique case (apb_state_reg)
                pcdcs_pkg::PCDCS_ST_IDLE: begin
                    if (psel && penable) begin
                        apb_state_reg <= pcdcs_pkg::PCDCS_ST_RESP;
                        pready_reg    <= 1'b1;
                    end
                end
                pcdcs_pkg::PCDCS_ST_RESP: begin
                    apb_state_reg <= pcdcs_pkg::PCDCS_ST_IDLE;
                    pready_reg    <= 1'b0;
                end
            endcase
        end
    end

    assign wr_fire = psel && penable && pready_reg && pwrite;
    assign wr_sel  = wr_fire ? addr_sel(paddr) : 4'h0;

    // ------------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------------
    always_comb begin
        rd_word = '0; // R9 R10 R16 R17
        unique case (addr_sel(paddr))
            4'h1: begin
                rd_word[`PCDCS_ERR_MSB:0]                = err_en_reg;
                rd_word[`PCDCS_MPS_MSB:`PCDCS_MPS_LSB]   = max_payload_sel_reg;
                rd_word[`PCDCS_WTAG_BIT]                 = wide_tag_en_reg;
                rd_word[`PCDCS_RO_BIT]                   = 1'b0; // R5
            end
            4'h2: rd_word[`PCDCS_ERR_MSB:0] = err_seen_reg;
            4'h4: rd_word[`PCDCS_ERR_MSB:0] = err_mask_reg;
            4'h8: rd_word[`PCDCS_SEQUENTIAL_TAG_DEBUG_BIT] = sequential_tag_debug_reg;
            default: rd_word = '0;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_reg   <= '0;
            pslverr_reg  <= 1'b0;
            rsp_ctrl_reg <= 1'b0;
            rsp_stat_reg <= 1'b0;
        end else if (apb_state_reg == pcdcs_pkg::PCDCS_ST_IDLE && psel && penable) begin
            prdata_reg   <= pwrite ? '0 : rd_word;
            pslverr_reg  <= (addr_sel(paddr) == 4'h0);
            rsp_ctrl_reg <= !pwrite && (addr_sel(paddr) == 4'h1);
            rsp_stat_reg <= !pwrite && (addr_sel(paddr) == 4'h2);
        end else begin
            prdata_reg   <= '0;
            pslverr_reg  <= 1'b0;
            rsp_ctrl_reg <= 1'b0;
            rsp_stat_reg <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // Control register
    // ------------------------------------------------------------------
    // Bits 4 and 9 to 15 have no storage, so writes there fall away
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            err_en_reg          <= `PCDCS_ERR_RST;
            max_payload_sel_reg <= `PCDCS_MPS_RST;
            wide_tag_en_reg     <= 1'b0;
        end else if (wr_sel[0]) begin
            if (pstrb[0]) begin
                err_en_reg          <= pwdata[`PCDCS_ERR_MSB:0]; // R1 R2 R3 R4
                max_payload_sel_reg <= pwdata[`PCDCS_MPS_MSB:`PCDCS_MPS_LSB]; // R6
            end
            if (pstrb[1]) begin
                wide_tag_en_reg <= pwdata[`PCDCS_WTAG_BIT]; // R8
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sequential_tag_debug_reg <= 1'b0;
            err_mask_reg             <= `PCDCS_ERR_RST;
        end else begin
            if (wr_sel[3] && pstrb[0]) begin
                sequential_tag_debug_reg <= pwdata[`PCDCS_SEQUENTIAL_TAG_DEBUG_BIT];
            end
            if (wr_sel[2] && pstrb[0]) begin
                err_mask_reg <= pwdata[`PCDCS_ERR_MSB:0];
            end
        end
    end

    // ------------------------------------------------------------------
    // Status register
    // ------------------------------------------------------------------
    assign err_clr = (wr_sel[1] && pstrb[0]) ? pwdata[`PCDCS_ERR_MSB:0] : 4'h0;

    // New detection wins over a clear in the same cycle
    assign err_seen_next = (err_seen_reg & ~err_clr) | err_det; // R13 R14 R15

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            err_seen_reg <= `PCDCS_ERR_RST;
        end else begin
            err_seen_reg <= err_seen_next;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            err_report_reg <= `PCDCS_ERR_RST;
        end else begin
            err_report_reg <= err_det & err_en_reg; // R1 R2 R3 R4 R18
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_reg <= 1'b0;
        end else begin
            irq_reg <= |(err_seen_reg & err_mask_reg);
        end
    end

    // ------------------------------------------------------------------
    // Transaction attributes
    // ------------------------------------------------------------------
    // Forwarded attributes pass with one register stage, untouched
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            max_payload_bytes_reg <= `PCDCS_BYTES_128;
            fwd_no_snoop_reg      <= 1'b0;
            fwd_len_reg           <= '0;
        end else begin
            max_payload_bytes_reg <= payload_bytes(max_payload_sel_reg); // R6 R7
            fwd_no_snoop_reg      <= fwd_no_snoop_in; // R11
            fwd_len_reg           <= fwd_len_in; // R12
        end
    end

    pcdcs_tag_gen u_tag_gen (
        .pclk        (pclk),
        .presetn     (presetn),
        .seq_debug   (sequential_tag_debug_reg),
        .wide_tag_en (wide_tag_en_reg),
        .tag_req     (tag_req),
        .tag         (req_tag)
    );

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign prdata              = prdata_reg;
    assign pready              = pready_reg;
    assign pslverr             = pslverr_reg;
    assign corr_err_report     = err_report_reg[`PCDCS_CORR_BIT];
    assign nonfatal_err_report = err_report_reg[`PCDCS_NFAT_BIT];
    assign fatal_err_report    = err_report_reg[`PCDCS_FAT_BIT];
    assign unsup_req_report    = err_report_reg[`PCDCS_UNSUP_BIT];
    assign max_payload_bytes   = max_payload_bytes_reg;
    assign req_max_read_bytes  = `PCDCS_BYTES_128; // R12
    assign req_relaxed_order   = 1'b0; // R5
    assign req_no_snoop        = 1'b0; // R11
    assign fwd_no_snoop_out    = fwd_no_snoop_reg;
    assign fwd_len_out         = fwd_len_reg;
    assign irq                 = irq_reg;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    a_corr_report_on: assert property ( // R1
        @(posedge pclk) disable iff (!presetn)
        (corr_err_det && err_en_reg[`PCDCS_CORR_BIT]) |=> corr_err_report)
        else $error("enabled correctable error not reported");

    a_nonfatal_gated: assert property ( // R2
        @(posedge pclk) disable iff (!presetn)
        nonfatal_err_report |-> $past(err_en_reg[`PCDCS_NFAT_BIT] && nonfatal_err_det))
        else $error("non-fatal report without enable");

    a_fatal_gated: assert property ( // R3
        @(posedge pclk) disable iff (!presetn)
        (fatal_err_det && !err_en_reg[`PCDCS_FAT_BIT]) |=> !fatal_err_report)
        else $error("fatal report while disabled");

    a_unsup_once: assert property ( // R4
        @(posedge pclk) disable iff (!presetn)
        (unsup_req_det && err_en_reg[`PCDCS_UNSUP_BIT]) ##1 !unsup_req_det
        |=> !unsup_req_report)
        else $error("unsupported request reported twice");

    a_ctrl_ro_zero: assert property ( // R9
        @(posedge pclk) disable iff (!presetn)
        (rsp_ctrl_reg && pready_reg) |-> (prdata[15:9] == 7'h00) && !prdata[`PCDCS_RO_BIT])
        else $error("read-only control bits not zero");

    a_payload_map: assert property ( // R7
        @(posedge pclk) disable iff (!presetn)
        ##1 (max_payload_bytes == payload_bytes($past(max_payload_sel_reg))))
        else $error("payload size mismatch");

    a_fatal_sticky: assert property ( // R14
        @(posedge pclk) disable iff (!presetn)
        (err_seen_reg[`PCDCS_FAT_BIT] && !err_clr[`PCDCS_FAT_BIT])
        |=> err_seen_reg[`PCDCS_FAT_BIT])
        else $error("fatal status lost");

    a_unsup_set: assert property ( // R15
        @(posedge pclk) disable iff (!presetn)
        unsup_req_det |=> err_seen_reg[`PCDCS_UNSUP_BIT] [*1] ##1 1'b1)
        else $error("unsupported request not logged");

    a_seen_ignores_en: assert property ( // R13
        @(posedge pclk) disable iff (!presetn)
        (corr_err_det && !err_en_reg[`PCDCS_CORR_BIT]) |=> err_seen_reg[`PCDCS_CORR_BIT])
        else $error("correctable error not logged while disabled");

    a_stat_ro_zero: assert property ( // R16 R17
        @(posedge pclk) disable iff (!presetn)
        (rsp_stat_reg && pready_reg) |-> (prdata[15:4] == 12'h000))
        else $error("read-only status bits not zero");

    a_apb_one_wait: assert property (
        @(posedge pclk) disable iff (!presetn)
        (psel && penable && !pready_reg) |=> pready_reg ##1 !pready_reg)
        else $error("apb answer timing wrong");

    c_ctrl_write: cover property (
        @(posedge pclk) disable iff (!presetn)
        wr_sel[0] ##1 (max_payload_sel_reg == `PCDCS_MPS_2048));

    c_status_clear: cover property (
        @(posedge pclk) disable iff (!presetn)
        err_seen_reg[`PCDCS_FAT_BIT] && err_clr[`PCDCS_FAT_BIT] ##1 !err_seen_reg[`PCDCS_FAT_BIT]);

    c_fatal_report: cover property (
        @(posedge pclk) disable iff (!presetn)
        fatal_err_report ##[1:4] irq);

endmodule : pcdcs_regs

// ### dv/testbench.sv
// Purpose: Self-checking bench for the device control and status bank
// Assumes: APB slave answers when ready; the bench waits on pready
// Notes:   No random stimulus; pstrb is tied high, other inputs are set at time zero and then driven from pclk edges
`timescale 1ns/1ps
`include "pcdcs_params.svh"

module testbench;
    logic        pclk, presetn, psel, penable, pwrite, tag_req, fwd_ns;
    logic        pready, pslverr, rro, rns, fno, irq, err;
    logic [11:0] paddr, fwd_len, mpb, rmb, flo;
    logic [31:0] pwdata, prdata, rd;
    logic [3:0]  det, rep, en;
    logic [7:0]  rtag;
    int          mismatches, comparisons;

    pcdcs_regs u_pcdcs_regs (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(4'hf), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .corr_err_det(det[0]), .nonfatal_err_det(det[1]),
        .fatal_err_det(det[2]), .unsup_req_det(det[3]), .tag_req(tag_req),
        .fwd_no_snoop_in(fwd_ns), .fwd_len_in(fwd_len), .corr_err_report(rep[0]),
        .nonfatal_err_report(rep[1]), .fatal_err_report(rep[2]), .unsup_req_report(rep[3]),
        .max_payload_bytes(mpb), .req_max_read_bytes(rmb), .req_relaxed_order(rro),
        .req_no_snoop(rns), .fwd_no_snoop_out(fno), .fwd_len_out(flo), .req_tag(rtag),
        .irq(irq));

    initial begin
        pclk = 1'b0;
        forever #12.5 pclk = ~pclk;
    end

    // ------------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------------
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp, input string what);
        comparisons++;
        if (got !== exp) begin
            mismatches++;
            $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : cmp

    // Idle edge after each transfer so psel is never assigned twice in one step
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) mismatches++;
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb

    // Report stands in the cycle after the detect edge; sampled at the edge that ends it
    task automatic pulse(input logic [3:0] m);
        det <= m;
        @(posedge pclk);
        det <= 4'h0;
        @(posedge pclk);
        cmp({28'h0, rep}, {28'h0, m & en}, "report pulse");
        @(posedge pclk);
        cmp({28'h0, rep}, 32'h0, "report once");
    endtask : pulse

    task automatic tags(input int n);
        repeat (n) begin
            tag_req <= 1'b1;
            @(posedge pclk);
            tag_req <= 1'b0;
            @(posedge pclk);
        end
    endtask : tags

    task automatic tally_and_finish;
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : tally_and_finish

    // ------------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------------
    initial begin
        {presetn, psel, penable, pwrite, tag_req, fwd_ns} = 6'h0;
        {paddr, fwd_len, pwdata, det, en} = '0;
        mismatches = 0;
        comparisons = 0;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(1'b0, `PCDCS_CTRL_ADDR, 32'h0);
        cmp(rd, 32'h0, "ctrl reset");
        cmp({20'h0, mpb}, 32'h80, "payload reset");
        apb(1'b1, `PCDCS_CTRL_ADDR, 32'hffff);
        apb(1'b0, `PCDCS_CTRL_ADDR, 32'h0);
        cmp(rd, 32'h1ef, "ctrl fixed bits");
        apb(1'b1, `PCDCS_STAT_ADDR, 32'hffff);
        apb(1'b0, `PCDCS_STAT_ADDR, 32'h0);
        cmp(rd, 32'h0, "status fixed bits");
        apb(1'b0, 12'h300, 32'h0);
        cmp({31'h0, err}, 32'h1, "unmapped");
        $display("test access done");
        for (int c = 0; c < 8; c++) begin
            apb(1'b1, `PCDCS_CTRL_ADDR, 32'(c << 5));
            // Payload size lags the field by one register stage
            @(posedge pclk);
            cmp({20'h0, mpb}, 32'(c < 5 ? 128 << c : 128), "payload size");
        end
        $display("test payload done");
        fwd_ns <= 1'b1;
        fwd_len <= 12'h3ff;
        repeat (2) @(posedge pclk);
        cmp({29'h0, rro, rns, fno}, 32'h1, "attributes");
        cmp({8'h0, rmb, flo}, {8'h0, 12'h080, 12'h3ff}, "sizes");
        $display("test forward done");
        // Second pass: reports and interrupt both masked, status still logs
        for (int p = 0; p < 2; p++) begin
            en = p ? 4'h0 : 4'hf;
            apb(1'b1, `PCDCS_CTRL_ADDR, {28'h0, en});
            apb(1'b1, `PCDCS_MASK_ADDR, {28'h0, en});
            for (int i = 0; i < 4; i++) pulse(4'h1 << i);
            apb(1'b0, `PCDCS_STAT_ADDR, 32'h0);
            cmp(rd, 32'hf, "status set");
            cmp({31'h0, irq}, {31'h0, |en}, "irq level");
            apb(1'b1, `PCDCS_STAT_ADDR, 32'h4);
            apb(1'b0, `PCDCS_STAT_ADDR, 32'h0);
            cmp(rd, 32'hb, "fatal cleared alone");
            apb(1'b1, `PCDCS_STAT_ADDR, 32'hb);
            apb(1'b0, `PCDCS_STAT_ADDR, 32'h0);
            cmp(rd, 32'h0, "status cleared");
            cmp({31'h0, irq}, 32'h0, "irq cleared");
        end
        $display("test events done");
        apb(1'b1, `PCDCS_TLC_ADDR, 32'h1);
        apb(1'b1, `PCDCS_CTRL_ADDR, 32'h0);
        tags(31);
        cmp({24'h0, rtag}, {24'h0, `PCDCS_NARROW_TAG_MAX}, "narrow top");
        tags(1);
        cmp({24'h0, rtag}, 32'h0, "narrow wrap");
        apb(1'b1, `PCDCS_CTRL_ADDR, 32'h100);
        tags(32);
        cmp({24'h0, rtag}, 32'h20, "wide range");
        apb(1'b1, `PCDCS_TLC_ADDR, 32'h0);
        // Tag clears one edge after the debug bit drops
        @(posedge pclk);
        cmp({24'h0, rtag}, 32'h0, "tag off");
        $display("test tag done");
        tally_and_finish();
    end

    initial begin
        #100000;
        mismatches++;
        tally_and_finish();
    end
endmodule : testbench
